/* File: include/fcs_defs.svh */
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define FCS_OFS_CTRL 11'h400
`define FCS_OFS_STATUS 11'h401
`define FCS_OFS_TAP3 11'h41C
`define FCS_OFS_TAP4 11'h41E
`define FCS_OFS_CENTER 11'h420
`define FCS_OFS_TAP6 11'h423
`define FCS_OFS_TAP7 11'h425

// storage masks: side registers are 16 bits wide, the center one 24
`define FCS_MASK_SIDE 24'h00FFFF
`define FCS_MASK_CENTER 24'hFFFFFF

// field positions
`define FCS_SIDE_MSB 11
`define FCS_CENTER_MSB 17
`define FCS_CTRL_MODE_LSB 0
`define FCS_CTRL_SCW_LSB 2
`define FCS_CTRL_MERGE_BIT 5
`define FCS_STAT_LINK_BIT 0
`define FCS_STAT_CHAN_A_BIT 1
`define FCS_STAT_MERGED_BIT 2

// reset values and side-weight limit
`define FCS_RST_COEFF 24'h000000
`define FCS_RST_CTRL 8'h00
`define FCS_SCW_MAX 3'h6

`endif

/* File: include/fcs_pkg.sv */
package fcs_pkg;

    typedef enum logic [1:0] {
        FCS_IDLE = 2'b01,
        FCS_RESP = 2'b10
    } fcs_bus_state_t;

    typedef enum logic [1:0] {
        FCS_MODE_BYPASS = 2'h0,
        FCS_MODE_RSVD1 = 2'h1,
        FCS_MODE_ENABLE = 2'h2,
        FCS_MODE_RSVD3 = 2'h3
    } fcs_mode_t;

    // all coefficients leave on a common grid with lsb weight 2^-16
    typedef logic signed [17:0] fcs_coeff_t;

endpackage : fcs_pkg

/* File: logic/fcs_side_scale.sv */
`include "fcs_defs.svh"

module fcs_side_scale (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] side_coeff,
    input wire logic [2:0] side_weight_setting,
    output fcs_pkg::fcs_coeff_t scaled
);

    logic [2:0] shift;
    fcs_pkg::fcs_coeff_t next_scaled;

    always_comb begin
        // settings above the limit are held at the limit
        if (side_weight_setting > `FCS_SCW_MAX) begin
            shift = `FCS_SCW_MAX;
        end else begin
            shift = side_weight_setting;
        end
        // signed 12-bit field widened, then weighted by 2^shift
        next_scaled = fcs_pkg::fcs_coeff_t'({{6{side_coeff[11]}}, side_coeff}) <<< shift;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scaled <= 18'h00000;
        end else begin
            scaled <= next_scaled;
        end
    end

endmodule : fcs_side_scale

/* File: logic/fcs_tap_store.sv */
// Operation
// - each side coefficient is the signed 12-bit value in bits 11:0 of its 16-bit register.
// - index 0x41C holds tap three, feeding channel A in dual mode or the merged filter.
// - index 0x41E holds tap four, feeding channel A in dual mode or the merged filter.
// - index 0x420 holds the center tap as a signed 18-bit value, bits 23:18 reserved.
// - the filter has nine taps and only the fifth, the center, has 18-bit resolution.
// - index 0x423 holds tap six, feeding channel A in dual mode or the merged filter.
// - index 0x425 holds tap seven, feeding channel A in dual mode or the merged filter.
// - a filter mode of 0 bypasses the filter, 2 enables it, and 1 and 3 are reserved.
`include "fcs_defs.svh"

module fcs_tap_store (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [10:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_link_enable,
    output fcs_pkg::fcs_coeff_t tap3_coefficient,
    output fcs_pkg::fcs_coeff_t tap4_coefficient,
    output fcs_pkg::fcs_coeff_t center_tap_coefficient,
    output fcs_pkg::fcs_coeff_t tap6_coefficient,
    output fcs_pkg::fcs_coeff_t tap7_coefficient,
    output logic chan_a_filter_on,
    output logic merged_filter_on
);

    localparam int NREG = 5;
    localparam logic [10:0] OFS [NREG] = '{`FCS_OFS_TAP3, `FCS_OFS_TAP4, `FCS_OFS_CENTER,
                                         `FCS_OFS_TAP6, `FCS_OFS_TAP7};
    localparam logic [23:0] MASK [NREG] = '{`FCS_MASK_SIDE, `FCS_MASK_SIDE, `FCS_MASK_CENTER,
                                          `FCS_MASK_SIDE, `FCS_MASK_SIDE};

    fcs_pkg::fcs_bus_state_t state;
    fcs_pkg::fcs_bus_state_t next_state;
    logic next_waitrequest;
    logic [31:0] next_readdata;
    logic [NREG-1:0] sel;
    logic ctrl_hit;
    logic stat_hit;
    logic commit;

    logic [23:0] coeff [NREG];
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    fcs_pkg::fcs_mode_t mode;
    logic [2:0] scw;
    logic merge;

    fcs_pkg::fcs_coeff_t next_center;
    logic next_chan_a_on;
    logic next_merged_on;

    assign mode = fcs_pkg::fcs_mode_t'(ctrl[`FCS_CTRL_MODE_LSB +: 2]);
    assign scw = ctrl[`FCS_CTRL_SCW_LSB +: 3];
    assign merge = ctrl[`FCS_CTRL_MERGE_BIT];

    // address decode
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            sel[i] = (avs_address == OFS[i]);
        end
        ctrl_hit = (avs_address == `FCS_OFS_CTRL);
        stat_hit = (avs_address == `FCS_OFS_STATUS);
    end

    // a write lands on the edge where waitrequest is seen low
    assign commit = (state == fcs_pkg::FCS_RESP) && avs_write;

    // bus handshake: one wait cycle, then one answer cycle
    always_comb begin
        next_state = state;
        next_waitrequest = 1'b1;
        next_readdata = avs_readdata;
        unique case (state)
            fcs_pkg::FCS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state = fcs_pkg::FCS_RESP;
                    next_waitrequest = 1'b0;
                    next_readdata = 32'h00000000;
                    if (avs_read) begin
                        for (int i = 0; i < NREG; i++) begin
                            if (sel[i]) begin
                                next_readdata = {8'h00, coeff[i] & MASK[i]};
                            end
                        end
                        if (ctrl_hit) begin
                            next_readdata = {24'h000000, ctrl};
                        end
                        if (stat_hit) begin
                            next_readdata[`FCS_STAT_LINK_BIT] = serial_link_enable;
                            next_readdata[`FCS_STAT_CHAN_A_BIT] = chan_a_filter_on;
                            next_readdata[`FCS_STAT_MERGED_BIT] = merged_filter_on;
                        end
                    end
                end
            end
            fcs_pkg::FCS_RESP: begin
                next_state = fcs_pkg::FCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fcs_pkg::FCS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            state <= next_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
        end
    end

    // coefficient registers, byte-lane writes, reserved bits kept
    for (genvar g = 0; g < NREG; g++) begin : g_coeff
        logic [23:0] next_coeff;

        always_comb begin
            next_coeff = coeff[g];
            if (commit && sel[g]) begin
                for (int b = 0; b < 3; b++) begin
                    if (avs_byteenable[b]) begin
                        next_coeff[b*8 +: 8] = avs_writedata[b*8 +: 8];
                    end
                end
                next_coeff = next_coeff & MASK[g];
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                coeff[g] <= `FCS_RST_COEFF;
            end else begin
                coeff[g] <= next_coeff;
            end
        end
    end

    // filter configuration
    always_comb begin
        next_ctrl = ctrl;
        if (commit && ctrl_hit && avs_byteenable[0]) begin
            next_ctrl = avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `FCS_RST_CTRL;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // side taps weighted by the side weight setting
    fcs_side_scale u_tap3 (
        .clk(clk),
        .rst_n(rst_n),
        .side_coeff(coeff[0][`FCS_SIDE_MSB:0]),
        .side_weight_setting(scw),
        .scaled(tap3_coefficient)
    );

    fcs_side_scale u_tap4 (
        .clk(clk),
        .rst_n(rst_n),
        .side_coeff(coeff[1][`FCS_SIDE_MSB:0]),
        .side_weight_setting(scw),
        .scaled(tap4_coefficient)
    );

    fcs_side_scale u_tap6 (
        .clk(clk),
        .rst_n(rst_n),
        .side_coeff(coeff[3][`FCS_SIDE_MSB:0]),
        .side_weight_setting(scw),
        .scaled(tap6_coefficient)
    );

    fcs_side_scale u_tap7 (
        .clk(clk),
        .rst_n(rst_n),
        .side_coeff(coeff[4][`FCS_SIDE_MSB:0]),
        .side_weight_setting(scw),
        .scaled(tap7_coefficient)
    );

    // center tap keeps its full 18 bits, no side weighting; reserved modes bypass
    always_comb begin
        next_center = fcs_pkg::fcs_coeff_t'(coeff[2][`FCS_CENTER_MSB:0]);
        next_chan_a_on = (mode == fcs_pkg::FCS_MODE_ENABLE) && !merge;
        next_merged_on = (mode == fcs_pkg::FCS_MODE_ENABLE) && merge;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            center_tap_coefficient <= 18'h00000;
            chan_a_filter_on <= 1'b0;
            merged_filter_on <= 1'b0;
        end else begin
            center_tap_coefficient <= next_center;
            chan_a_filter_on <= next_chan_a_on;
            merged_filter_on <= next_merged_on;
        end
    end

    // checks
    logic [11:0] tap3_field;
    logic [11:0] tap4_field;
    logic [17:0] center_field;
    logic [15:0] tap6_word;
    logic [15:0] tap7_word;

    assign tap3_field = coeff[0][11:0];
    assign tap4_field = coeff[1][11:0];
    assign center_field = coeff[2][17:0];
    assign tap6_word = coeff[3][15:0];
    assign tap7_word = coeff[4][15:0];

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!rst_n);

    side_sign_ext_a: assert property ($past(scw) == 3'h0 |->
        tap3_coefficient == {{6{$past(tap3_field[11])}}, $past(tap3_field)})
        else $error("tap three output is not the sign-extended field");

    tap3_write_a: assert property (commit && avs_address == `FCS_OFS_TAP3
        && avs_byteenable == 4'hF |=> coeff[0] == {8'h00, $past(avs_writedata[15:0])})
        else $error("tap three register missed its write");

    tap4_path_a: assert property (commit && avs_address == `FCS_OFS_TAP4
        && avs_byteenable == 4'hF && scw == 3'h0 && next_ctrl == ctrl
        |=> ##1 tap4_coefficient == {{6{$past(avs_writedata[11], 2)}}, $past(avs_writedata[11:0], 2)})
        else $error("tap four output does not follow its write");

    center_follow_a: assert property (center_tap_coefficient == $past(center_field))
        else $error("center output does not follow its register");

    center_res_a: assert property (commit && avs_address == `FCS_OFS_CENTER
        && avs_byteenable == 4'hF |=> ##1 center_tap_coefficient == $past(avs_writedata[17:0], 2))
        else $error("center tap lost resolution");

    tap6_write_a: assert property (commit && avs_address == `FCS_OFS_TAP6
        && avs_byteenable == 4'hF |=> tap6_word == $past(avs_writedata[15:0]))
        else $error("tap six register missed its write");

    tap7_write_a: assert property (commit && avs_address == `FCS_OFS_TAP7
        && avs_byteenable == 4'hF |=> tap7_word == $past(avs_writedata[15:0]))
        else $error("tap seven register missed its write");

    mode_gate_a: assert property ((chan_a_filter_on || merged_filter_on)
        == ($past(mode) == fcs_pkg::FCS_MODE_ENABLE))
        else $error("filter enable does not match the mode field");

    side_weight_a: assert property ($past(scw) >= `FCS_SCW_MAX |->
        tap7_coefficient[5:0] == 6'h00 && tap6_coefficient[5:0] == 6'h00)
        else $error("side weight shift not applied");

    read_back_a: assert property (state == fcs_pkg::FCS_IDLE && avs_read
        && avs_address == `FCS_OFS_TAP3 |=> !avs_waitrequest
        && avs_readdata == {16'h0000, $past(coeff[0][15:0])})
        else $error("tap three read-back wrong");

    tap4_read_a: assert property (state == fcs_pkg::FCS_IDLE && avs_read
        && avs_address == `FCS_OFS_TAP4 |=> avs_readdata == {16'h0000, $past(coeff[1][15:0])})
        else $error("tap four read-back wrong");

    tap7_read_a: assert property (state == fcs_pkg::FCS_IDLE && avs_read
        && avs_address == `FCS_OFS_TAP7 |=> avs_readdata == {16'h0000, $past(tap7_word)})
        else $error("tap seven read-back wrong");

    center_read_a: assert property (state == fcs_pkg::FCS_IDLE && avs_read
        && avs_address == `FCS_OFS_CENTER |=> avs_readdata == {8'h00, $past(coeff[2])})
        else $error("center read-back wrong");

    center_write_a: assert property (commit && avs_address == `FCS_OFS_CENTER
        && avs_byteenable == 4'hF |=> coeff[2] == $past(avs_writedata[23:0]))
        else $error("center register lost its reserved bits");

    chan_route_a: assert property (chan_a_filter_on
        == ($past(mode) == fcs_pkg::FCS_MODE_ENABLE && !$past(merge)))
        else $error("channel A enable does not follow mode and merge");

    unmapped_read_a: assert property (state == fcs_pkg::FCS_IDLE && avs_read && !(|sel)
        && !ctrl_hit && !stat_hit |=> avs_readdata == 32'h00000000)
        else $error("unmapped read did not return zero");

    bus_answer_a: assert property (state == fcs_pkg::FCS_IDLE && (avs_read || avs_write)
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest answer not one cycle after the request");

    cov_center_write: cover property (commit && avs_address == `FCS_OFS_CENTER);
    cov_merged_on: cover property (merged_filter_on);
    cov_chan_a_on: cover property (chan_a_filter_on && scw == `FCS_SCW_MAX);
    cov_unmapped_read: cover property (state == fcs_pkg::FCS_RESP && avs_read
        && !(|sel) && !ctrl_hit && !stat_hit);
    cov_rsvd_mode: cover property (mode == fcs_pkg::FCS_MODE_RSVD3 && merge);

endmodule : fcs_tap_store

/* File: sim/tb_top.sv */
`include "fcs_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [10:0] avs_address = 11'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic serial_link_enable = 1'b0;
    fcs_pkg::fcs_coeff_t tap_q [5];
    logic chan_a_filter_on;
    logic merged_filter_on;
    int fail_count = 0;
    int n_tests = 0;
    logic [10:0] adr [5];
    logic [31:0] pat [5];
    logic [31:0] rdat;

    always #50 clk = ~clk;

    fcs_tap_store dut (
        .clk(clk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .serial_link_enable(serial_link_enable),
        .tap3_coefficient(tap_q[0]),
        .tap4_coefficient(tap_q[1]),
        .center_tap_coefficient(tap_q[2]),
        .tap6_coefficient(tap_q[3]),
        .tap7_coefficient(tap_q[4]),
        .chan_a_filter_on(chan_a_filter_on),
        .merged_filter_on(merged_filter_on)
    );

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one bus transfer, held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [10:0] a, input logic [31:0] d,
            input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [10:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(rdat, exp);
    endtask : rd

    // outputs follow registers one edge later
    task automatic settle();
        repeat (2) @(posedge clk);
        #10;
    endtask : settle

    function automatic logic [31:0] mask_of(input int i);
        return (i == 2) ? `FCS_MASK_CENTER : `FCS_MASK_SIDE;
    endfunction : mask_of

    function automatic fcs_pkg::fcs_coeff_t exp_tap(input int i, input logic [2:0] s);
        logic [2:0] w;
        w = (s == 3'h7) ? 3'h6 : s;
        if (i == 2) begin
            return pat[i][17:0];
        end
        return fcs_pkg::fcs_coeff_t'({{6{pat[i][11]}}, pat[i][11:0]}) <<< w;
    endfunction : exp_tap

    initial begin
        #500000;
        fail_count++;
        end_of_test();
    end

    initial begin
        adr = '{`FCS_OFS_TAP3, `FCS_OFS_TAP4, `FCS_OFS_CENTER, `FCS_OFS_TAP6, `FCS_OFS_TAP7};
        for (int i = 0; i < 5; i++) begin
            pat[i] = (32'hA5A59801 + 32'h111 * i) ^ (32'(i % 2) << 11);
        end
        pat[2] = 32'h55FACE12;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], 32'h0);
            chk(tap_q[i], 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            wr(adr[i], pat[i]);
        end
        settle();
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], pat[i] & mask_of(i));
            chk(tap_q[i], exp_tap(i, 3'h0));
        end
        for (int s = 0; s < 8; s++) begin
            wr(`FCS_OFS_CTRL, 32'(s) << 2);
            settle();
            for (int i = 0; i < 5; i++) begin
                chk(tap_q[i], exp_tap(i, 3'(s)));
            end
        end
        for (int g = 0; g < 2; g++) begin
            for (int m = 0; m < 4; m++) begin
                wr(`FCS_OFS_CTRL, 32'hC0 | (32'(g) << 5) | 32'(m));
                settle();
                chk(chan_a_filter_on, m == 2 && g == 0);
                chk(merged_filter_on, m == 2 && g == 1);
                rd(`FCS_OFS_CTRL, 32'hC0 | (32'(g) << 5) | 32'(m));
                // link raised only between configuration writes
                serial_link_enable <= g[0];
                rd(`FCS_OFS_STATUS, {29'h0, m == 2 && g == 1, m == 2 && g == 0, g[0]});
                serial_link_enable <= 1'b0;
            end
        end
        wr(`FCS_OFS_CTRL, 32'h0);
        xfer(1'b1, `FCS_OFS_CENTER, 32'hFF000077, 4'h1);
        settle();
        rd(`FCS_OFS_CENTER, (pat[2] & 32'h00FFFF00) | 32'h77);
        chk(tap_q[2], {{14{pat[2][17]}}, pat[2][17:8], 8'h77});
        wr(11'h41D, 32'hFFFF);
        rd(11'h41D, 32'h0);
        rd(`FCS_OFS_TAP3, pat[0] & `FCS_MASK_SIDE);
        @(posedge clk);
        rst_n <= 1'b0;
        settle();
        for (int i = 0; i < 5; i++) begin
            chk(tap_q[i], 32'h0);
        end
        @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], 32'h0);
        end
        end_of_test();
    end
endmodule : tb_top
